// [src/dcr_axil.sv]
// axi4-lite slave front end for the register bank
`timescale 1ns/1ns
module dcr_axil
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  dcr_reg_if.bus rif
);
  typedef struct packed {
    dcr_wst_e ws;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    dcr_rst_e rs;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } dcr_axil_s;

  localparam dcr_axil_s AXIL_RST = '{ws: DCR_W_IDLE, rs: DCR_R_IDLE,
                                     default: '0};

  dcr_axil_s q, d;

  assign s_axi_awready = (q.ws == DCR_W_IDLE) && !q.aw_have;
  assign s_axi_wready = (q.ws == DCR_W_IDLE) && !q.w_have;
  assign s_axi_bvalid = (q.ws == DCR_W_RESP);
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = (q.rs == DCR_R_IDLE);
  assign s_axi_rvalid = (q.rs == DCR_R_DATA);
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  always_comb begin
    d = q;
    rif.wr = 1'b0;
    rif.addr_w = q.awaddr;
    rif.wdata = q.wdata;
    rif.wstrb = q.wstrb;
    rif.rd = s_axi_arvalid && s_axi_arready;
    rif.addr_r = s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    unique case (q.ws)
      DCR_W_IDLE: begin
        // both halves held, so the write lands one cycle after the later
        if (q.aw_have && q.w_have) begin
          rif.wr = 1'b1;
          d.aw_have = 1'b0;
          d.w_have = 1'b0;
          d.bresp = rif.whit ? RESP_OKAY : RESP_SLVERR;
          d.ws = DCR_W_RESP;
        end
      end
      DCR_W_RESP: begin
        if (s_axi_bready) begin
          d.ws = DCR_W_IDLE;
        end
      end
      default: d.ws = DCR_W_IDLE;
    endcase
    unique case (q.rs)
      DCR_R_IDLE: begin
        if (rif.rd) begin
          d.rdata = rif.rdata;
          d.rresp = rif.rhit ? RESP_OKAY : RESP_SLVERR;
          d.rs = DCR_R_DATA;
        end
      end
      DCR_R_DATA: begin
        if (s_axi_rready) begin
          d.rs = DCR_R_IDLE;
        end
      end
      default: d.rs = DCR_R_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= AXIL_RST;
    end else begin
      q <= d;
    end
  end
endmodule // dcr_axil

// [src/dcr_pkg.sv]
// constants and types for the switch port device control register block
package dcr_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] DCR_CTL_OFS = 12'h0C8;
  localparam logic [ADDR_W-1:0] DCR_ISTAT_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] DCR_IEN_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] DCR_ICLR_OFS = 12'h108;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // field positions in the control/status word
  // ****************************************
  localparam int NUM_ERR = 4;
  localparam int F_ERR_EN_LO = 0;
  localparam int F_RELAX = 4;
  localparam int F_MPS_LO = 5;
  localparam int F_EXT_TAG = 8;
  localparam int F_PHANTOM = 9;
  localparam int F_AUX_PM = 10;
  localparam int F_NO_SNOOP = 11;
  localparam int F_MRRS_LO = 12;
  localparam int F_RSVD = 15;
  localparam int F_ERR_DET_LO = 16;
  localparam int F_AUX_DET = 20;

  // ****************************************
  // reset values and payload codes
  // ****************************************
  localparam logic [NUM_ERR-1:0] ERR_EN_RST = 4'h0;
  localparam logic [2:0] MPS_RST = 3'h0;
  localparam logic [2:0] MPS_SUPP_SMALL = 3'h1;
  localparam logic [2:0] MPS_SUPP_LARGE = 3'h2;
  localparam logic EXT_TAG_RST = 1'h0;
  localparam logic AUX_PM_RST = 1'h0;

  // ****************************************
  // bus slave states
  // ****************************************
  typedef enum logic [1:0] {
    DCR_W_IDLE = 2'h1,
    DCR_W_RESP = 2'h2
  } dcr_wst_e;
  typedef enum logic [1:0] {
    DCR_R_IDLE = 2'h1,
    DCR_R_DATA = 2'h2
  } dcr_rst_e;
endpackage

// [src/dcr_reg_if.sv]
// register access port between bus slave and register bank
`timescale 1ns/1ns
interface dcr_reg_if;
  import dcr_pkg::*;
  logic wr;
  logic [ADDR_W-1:0] addr_w;
  logic [DATA_W-1:0] wdata;
  logic [3:0] wstrb;
  logic whit;
  logic rd;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] rdata;
  logic rhit;
  modport bus (output wr, addr_w, wdata, wstrb, rd, addr_r,
               input whit, rdata, rhit);
  modport regs (input wr, addr_w, wdata, wstrb, rd, addr_r,
                output whit, rdata, rhit);
endinterface

// [src/dcr_top.sv]
// switch port device control register bank with error logging
`timescale 1ns/1ns
module dcr_top
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hot_resetn,
  input wire logic large_payload_strap,
  input wire logic aux_power_present,
  input wire logic [NUM_ERR-1:0] err_event,
  output logic [NUM_ERR-1:0] err_report,
  output logic [2:0] max_payload,
  output logic ext_tag_en,
  output logic aux_pm_en,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // state
  // ****************************************
  // pin index 0 is the payload strap, 1 the aux power detect
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] pins;
    logic [NUM_ERR-1:0] err_en;
    logic [2:0] mps;
    logic ext_tag;
    logic aux_pm;
    logic [NUM_ERR-1:0] err_det;
    logic [NUM_ERR-1:0] int_stat;
    logic [NUM_ERR-1:0] int_en;
    logic [NUM_ERR-1:0] report;
  } dcr_top_s;

  localparam dcr_top_s TOP_RST = '0;

  dcr_top_s q, d;
  dcr_reg_if rif ();

  // ****************************************
  // bus slave
  // ****************************************
  dcr_axil u_axil (
    .clk(clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif)
  );

  // ****************************************
  // decode helpers
  // ****************************************
  // low two address bits are ignored: every register is one word
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] w;
    w = a[ADDR_W-1:2];
    reg_hit = (w == DCR_CTL_OFS[ADDR_W-1:2]) ||
              (w == DCR_ISTAT_OFS[ADDR_W-1:2]) ||
              (w == DCR_IEN_OFS[ADDR_W-1:2]) ||
              (w == DCR_ICLR_OFS[ADDR_W-1:2]);
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] ofs);
    is_reg = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  logic [2:0] mps_supp;
  logic [DATA_W-1:0] ctl_word;
  logic ctl_wr;

  assign mps_supp = q.pins[0] ? MPS_SUPP_LARGE : MPS_SUPP_SMALL;
  assign ctl_wr = rif.wr && is_reg(rif.addr_w, DCR_CTL_OFS);

  always_comb begin
    ctl_word = '0;
    ctl_word[F_ERR_EN_LO +: NUM_ERR] = q.err_en;
    ctl_word[F_MPS_LO +: 3] = q.mps;
    ctl_word[F_EXT_TAG] = q.ext_tag;
    ctl_word[F_AUX_PM] = q.aux_pm;
    ctl_word[F_ERR_DET_LO +: NUM_ERR] = q.err_det;
    ctl_word[F_AUX_DET] = q.pins[1];
  end

  assign rif.whit = reg_hit(rif.addr_w);
  assign rif.rhit = reg_hit(rif.addr_r);

  always_comb begin
    rif.rdata = '0;
    if (is_reg(rif.addr_r, DCR_CTL_OFS)) begin
      rif.rdata = ctl_word;
    end else if (is_reg(rif.addr_r, DCR_ISTAT_OFS)) begin
      rif.rdata[NUM_ERR-1:0] = q.int_stat;
    end else if (is_reg(rif.addr_r, DCR_IEN_OFS)) begin
      rif.rdata[NUM_ERR-1:0] = q.int_en;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    // pins: a change counts once the second and third stages agree
    d.sync1 = {aux_power_present, large_payload_strap};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.pins = (q.sync2 & ~(q.sync2 ^ q.sync3)) |
             (q.pins & (q.sync2 ^ q.sync3));
    if (ctl_wr && rif.wstrb[0]) begin
      d.err_en = rif.wdata[F_ERR_EN_LO +: NUM_ERR];
      // oversize payload clamps to supported code
      d.mps = (rif.wdata[F_MPS_LO +: 3] > mps_supp) ?
              mps_supp : rif.wdata[F_MPS_LO +: 3];
    end
    if (ctl_wr && rif.wstrb[1]) begin
      d.ext_tag = rif.wdata[F_EXT_TAG];
      d.aux_pm = rif.wdata[F_AUX_PM];
    end
    if (ctl_wr && rif.wstrb[2]) begin
      d.err_det = q.err_det & ~rif.wdata[F_ERR_DET_LO +: NUM_ERR];
    end
    // log regardless of enables; set beats clear
    d.err_det = d.err_det | err_event;
    if (rif.wr && is_reg(rif.addr_w, DCR_IEN_OFS) && rif.wstrb[0]) begin
      d.int_en = rif.wdata[NUM_ERR-1:0];
    end
    if (rif.wr && is_reg(rif.addr_w, DCR_ICLR_OFS) && rif.wstrb[0]) begin
      d.int_stat = q.int_stat & ~rif.wdata[NUM_ERR-1:0];
    end
    d.int_stat = d.int_stat | err_event;
    d.report = err_event & q.err_en;
    // hot reset spares the sticky aux enable
    if (!hot_resetn) begin
      d.err_en = ERR_EN_RST;
      d.mps = MPS_RST;
      d.ext_tag = EXT_TAG_RST;
      d.err_det = '0;
      d.report = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign err_report = q.report;
  assign max_payload = q.mps;
  assign ext_tag_en = q.ext_tag;
  assign aux_pm_en = q.aux_pm;
  // a level that stays up until software clears or masks it
  assign irq = |(q.int_stat & q.int_en);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence ctl_lo_wr_s;
    ctl_wr && rif.wstrb[0] && hot_resetn;
  endsequence

  sequence corr_evt_s;
    err_event[0] && q.int_en[0] && hot_resetn;
  endsequence

  err_en_write_a: assert property (
    ctl_lo_wr_s |=> err_report == '0 ||
      q.err_en == $past(rif.wdata[NUM_ERR-1:0]))
    else $error("error enables did not take the written value");

  en_write_val_a: assert property (
    ctl_lo_wr_s |=> q.err_en == $past(rif.wdata[NUM_ERR-1:0]))
    else $error("error enables differ from written value");

  hot_reset_clr_a: assert property (
    !hot_resetn |=> q.err_en == ERR_EN_RST && q.mps == MPS_RST &&
      q.ext_tag == EXT_TAG_RST)
    else $error("hot reset left a control field set");

  ro_zero_read_a: assert property (
    rif.rd && is_reg(rif.addr_r, DCR_CTL_OFS) |->
      rif.rdata[F_RELAX] == 1'b0 && rif.rdata[F_PHANTOM] == 1'b0 &&
      rif.rdata[F_NO_SNOOP] == 1'b0 &&
      rif.rdata[F_MRRS_LO +: 3] == 3'h0 && rif.rdata[F_RSVD] == 1'b0)
    else $error("hardwired control bit read as one");

  mps_clamp_a: assert property (
    ctl_lo_wr_s and (rif.wdata[F_MPS_LO +: 3] > mps_supp)
      |=> q.mps == $past(mps_supp))
    else $error("oversize payload value was not clamped");

  mps_never_over_a: assert property (
    ctl_lo_wr_s |=> q.mps <= $past(mps_supp))
    else $error("payload setting above supported code");

  aux_sticky_a: assert property (
    !hot_resetn && !ctl_wr |=> $stable(q.aux_pm))
    else $error("aux power enable lost across hot reset");

  strap_sync_a: assert property (
    $changed(q.pins[0]) |-> $past(q.sync2[0]) == $past(q.sync3[0]))
    else $error("strap accepted before stages agreed");

  err_log_a: assert property (
    err_event[1] && !q.err_en[1] && hot_resetn |=> q.err_det[1])
    else $error("error not logged while reporting disabled");

  report_gate_a: assert property (
    err_event[2] && hot_resetn |=> err_report[2] == $past(q.err_en[2]))
    else $error("error reporting not gated by its enable");

  // a same-cycle enable write may mask the line, never the status
  irq_raise_a: assert property (
    corr_evt_s |=> q.int_stat[0] && (irq || !q.int_en[0]))
    else $error("enabled event did not raise the interrupt");

  // status bits clear on a write of one
  sequence det_clr_s;
    ctl_wr && rif.wstrb[2] && rif.wdata[F_ERR_DET_LO] && !err_event[0];
  endsequence

  sequence int_clr_s;
    rif.wr && is_reg(rif.addr_w, DCR_ICLR_OFS) && rif.wstrb[0] &&
      rif.wdata[1] && !err_event[1];
  endsequence

  det_w1c_a: assert property (
    det_clr_s |=> !q.err_det[0])
    else $error("detected error bit survived a write of one");

  int_w1c_a: assert property (
    int_clr_s |=> !q.int_stat[1])
    else $error("interrupt status bit survived a clear write");

  det_any_en_a: assert property (
    err_event[3] && hot_resetn |=> q.err_det[3] && q.int_stat[3])
    else $error("unsupported request error was not logged");
endmodule // dcr_top

// [test/dcr_tb.sv]
// self-checking bench for the device control register bank
`timescale 1ns/1ns
module testbench;
  import dcr_pkg::*;
  // ****************************************
  // clock, design and bench state
  // ****************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hot_resetn = 1'b1;
  logic strap = 1'b0;
  logic aux = 1'b1;
  logic [3:0] ev = 4'h0;
  logic [3:0] rep;
  logic [2:0] mps;
  logic ext, auxen, irq;
  logic [ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d, e, seed;
  logic [3:0] wstrb = 4'h0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp, r;
  int fails = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  dcr_top DUT (.clk(clk), .resetn(resetn), .hot_resetn(hot_resetn),
    .large_payload_strap(strap), .aux_power_present(aux),
    .err_event(ev), .err_report(rep), .max_payload(mps),
    .ext_tag_en(ext), .aux_pm_en(auxen), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy));
  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each channel holds until the edge at which its ready is seen high
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v,
      input logic [3:0] s, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr));
    do @(posedge clk); while (bv !== 1'b1);
    resp = bresp;
    brdy <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v,
      output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    v = rdata;
    resp = rresp;
    rrdy <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] m, input logic [3:0] x);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    @(negedge clk);
    chk({28'h0, rep}, {28'h0, x});
  endtask
  function automatic logic [31:0] exp_ctl(input logic [31:0] w,
      input logic big, input logic a);
    logic [2:0] sup;
    logic [2:0] m;
    sup = big ? 3'h2 : 3'h1;
    m = (w[7:5] > sup) ? sup : w[7:5];
    return {11'h0, a, 4'h0, 5'h00, w[10], 1'b0, w[8], m, 1'b0, w[3:0]};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
  initial begin
    seed = 32'h59;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(DCR_CTL_OFS, d, r);
    chk(d, 32'h0010_0000);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      if (i == 12) begin
        strap <= 1'b1;
        repeat (5) @(posedge clk);
      end
      // corner: low sixteen bits all ones, then the largest legal code for each strap
      d = (i % 12 == 0) ? 32'h0000_FFFF : seed;
      if (i == 11 || i == 23) d = {24'h0, strap ? 3'h2 : 3'h1, 5'h1F};
      e = exp_ctl(d, strap, aux);
      wr_reg(DCR_CTL_OFS, d, 4'h3, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rd_reg(DCR_CTL_OFS, d, r);
      chk(d, e);
      chk({29'h0, mps}, {29'h0, e[7:5]});
      chk({30'h0, ext, auxen}, {30'h0, e[8], e[10]});
    end
    $display("test random control writes done");
    wr_reg(DCR_CTL_OFS, 32'h0000_07FF, 4'h3, r);
    @(posedge clk);
    hot_resetn <= 1'b0;
    @(posedge clk);
    hot_resetn <= 1'b1;
    rd_reg(DCR_CTL_OFS, d, r);
    chk(d, 32'h0010_0400);
    @(posedge clk);
    resetn <= 1'b0;
    aux <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(DCR_CTL_OFS, d, r);
    chk(d, 32'h0000_0000);
    $display("test resets done");
    wr_reg(DCR_IEN_OFS, 32'h0000_000F, 4'h1, r);
    e = 32'h0;
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 4'h0);
      chk({31'h0, irq}, 32'h1);
      e[16+i] = 1'b1;
      rd_reg(DCR_CTL_OFS, d, r);
      chk(d, e);
    end
    wr_reg(DCR_CTL_OFS, 32'h000F_0000, 4'h4, r);
    rd_reg(DCR_CTL_OFS, d, r);
    chk(d, 32'h0);
    rd_reg(DCR_ISTAT_OFS, d, r);
    chk(d, 32'h0000_000F);
    wr_reg(DCR_ICLR_OFS, 32'h0000_000F, 4'h1, r);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr_reg(DCR_CTL_OFS, 32'h0000_000F, 4'h1, r);
    wr_reg(DCR_IEN_OFS, 32'h0000_0000, 4'h1, r);
    pulse(4'hF, 4'hF);
    chk({31'h0, irq}, 32'h0);
    wr_reg(DCR_CTL_OFS, 32'h0000_0009, 4'h1, r);
    pulse(4'hF, 4'h9);
    $display("test error logging and interrupt done");
    rd_reg(12'h200, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr_reg(12'h200, 32'hFFFF_FFFF, 4'hF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr_reg(DCR_ISTAT_OFS, 32'h0, 4'h1, r);
    rd_reg(DCR_ISTAT_OFS, d, r);
    chk(d, 32'h0000_000F);
    rd_reg(DCR_ICLR_OFS, d, r);
    chk(d, 32'h0);
    $display("test unmapped and read-only access done");
    end_sim();
  end
endmodule // testbench
